// [src/dcs_top.sv]
`timescale 1ns/1ns
`include "dcs_params.svh"
module dcs_top (
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  input  wire logic [7:0]        cmd_byte_in,
  input  wire logic              cmd_valid_in,
  output logic                   cmd_ready_out,
  output logic [7:0]             resp_byte_out,
  output logic                   resp_valid_out,
  input  wire logic              resp_ready_in,
  input  wire logic              debug_mode_in,
  input  wire logic              read_protect_in,
  output logic                   dmem_rd_out,
  output logic [15:0]            dmem_addr_out,
  input  wire logic [7:0]        dmem_data_in,
  output logic                   pmem_rd_out,
  output logic [15:0]            pmem_addr_out,
  input  wire logic [7:0]        pmem_data_in,
  output logic [7:0]             opcode_out,
  input  wire logic [2:0]        instr_len_in,
  output logic                   step_out,
  output logic                   stuff_out,
  output logic                   exec_out,
  output dcs_pkg::dcs_instr_t    instr_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `DCS_CRC_POLY : 16'h0000);
    return r;
  endfunction

  function automatic logic takes_byte(input dcs_pkg::dcs_state_t s);
    return (s == dcs_pkg::DCS_IDLE) || (s == dcs_pkg::DCS_ADDR_HI) ||
           (s == dcs_pkg::DCS_ADDR_LO) || (s == dcs_pkg::DCS_SIZE_HI) ||
           (s == dcs_pkg::DCS_SIZE_LO) || (s == dcs_pkg::DCS_OPCODE) ||
           (s == dcs_pkg::DCS_EXEC_BYT);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dcs_pkg::dcs_state_t state_reg, state_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [15:0] addr_reg, addr_next;
  logic [16:0] cnt_reg, cnt_next;
  logic [15:0] crc_reg, crc_next;
  logic [15:0] pcnt_reg, pcnt_next;
  logic        pend_reg;
  logic [2:0]  icnt_reg, icnt_next;
  logic        dmem_rd_next, pmem_rd_next;
  logic        step_next, stuff_next, exec_next;
  logic [7:0]  opcode_next;
  dcs_pkg::dcs_instr_t instr_next;
  logic        push_valid;
  logic [7:0]  push_data;
  logic        fifo_ready;

  wire       rx         = cmd_valid_in && cmd_ready_out;
  wire       cpu_ok     = debug_mode_in && !read_protect_in;
  wire [2:0] len_eff    = (instr_len_in == 3'h0) ? 3'h1 :
                          (instr_len_in > `DCS_MAX_INSTR) ? `DCS_MAX_INSTR : instr_len_in;
  wire       crc_done   = (pcnt_reg == `DCS_PMEM_BYTES) && !pmem_rd_out && !pend_reg;
  wire [7:0] rd_byte    = debug_mode_in ? dmem_data_in : `DCS_BLANK_BYTE;
  wire [15:0] crc_final = debug_mode_in ? crc_reg : `DCS_BLANK_CRC;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next   = state_reg;
    cmd_next     = cmd_reg;
    addr_next    = addr_reg;
    cnt_next     = cnt_reg;
    crc_next     = crc_reg;
    pcnt_next    = pcnt_reg;
    icnt_next    = icnt_reg;
    opcode_next  = opcode_out;
    instr_next   = instr_out;
    dmem_rd_next = 1'b0;
    pmem_rd_next = 1'b0;
    step_next    = 1'b0;
    stuff_next   = 1'b0;
    exec_next    = 1'b0;
    push_valid   = 1'b0;
    push_data    = 8'h00;
    case (state_reg)
      dcs_pkg::DCS_IDLE:
      begin
        if (rx)
        begin
          cmd_next = cmd_byte_in;
          case (cmd_byte_in)
            `DCS_CMD_RD_DATA: state_next = dcs_pkg::DCS_ADDR_HI;
            `DCS_CMD_RD_CRC:
            begin
              crc_next   = `DCS_CRC_INIT;
              pcnt_next  = 16'h0000;
              state_next = debug_mode_in ? dcs_pkg::DCS_CRC_RUN
                                         : dcs_pkg::DCS_CRC_HI;
            end
            `DCS_CMD_STEP:  step_next  = cpu_ok;
            `DCS_CMD_STUFF: state_next = dcs_pkg::DCS_OPCODE;
            `DCS_CMD_EXEC:  state_next = dcs_pkg::DCS_OPCODE;
            default:        state_next = dcs_pkg::DCS_IDLE;
          endcase
        end
      end
      dcs_pkg::DCS_ADDR_HI: if (rx) begin addr_next[15:8] = cmd_byte_in;
        state_next = dcs_pkg::DCS_ADDR_LO; end
      dcs_pkg::DCS_ADDR_LO: if (rx) begin addr_next[7:0] = cmd_byte_in;
        state_next = dcs_pkg::DCS_SIZE_HI; end
      dcs_pkg::DCS_SIZE_HI: if (rx) begin cnt_next = {1'b0, cmd_byte_in, 8'h00};
        state_next = dcs_pkg::DCS_SIZE_LO; end
      dcs_pkg::DCS_SIZE_LO:
      begin
        if (rx)
        begin
          cnt_next   = {1'b0, cnt_reg[15:8], cmd_byte_in};
          if ({cnt_reg[15:8], cmd_byte_in} == 16'h0000)
            cnt_next = 17'h10000;
          state_next = dcs_pkg::DCS_RD_ISSUE;
        end
      end
      dcs_pkg::DCS_RD_ISSUE:
      begin
        // A slot must be free before the read starts; the FIFO only drains meanwhile
        if (fifo_ready)
        begin
          dmem_rd_next = debug_mode_in;
          state_next   = dcs_pkg::DCS_RD_PUSH;
        end
      end
      dcs_pkg::DCS_RD_PUSH:
      begin
        if (!dmem_rd_out)
        begin
          push_valid = 1'b1;
          push_data  = rd_byte;
          addr_next  = addr_reg + 16'h0001;
          cnt_next   = cnt_reg - 17'h00001;
          state_next = (cnt_reg == 17'h00001) ? dcs_pkg::DCS_IDLE
                                              : dcs_pkg::DCS_RD_ISSUE;
        end
      end
      dcs_pkg::DCS_CRC_RUN:
      begin
        // One byte per clock, so the wait tracks the memory size
        if (pcnt_reg != `DCS_PMEM_BYTES)
        begin
          pmem_rd_next = 1'b1;
          pcnt_next    = pcnt_reg + 16'h0001;
        end
        if (pend_reg)
          crc_next = crc_byte(crc_reg, pmem_data_in);
        if (crc_done)
          state_next = dcs_pkg::DCS_CRC_HI;
      end
      dcs_pkg::DCS_CRC_HI:
      begin
        push_valid = 1'b1;
        push_data  = crc_final[15:8];
        if (fifo_ready)
          state_next = dcs_pkg::DCS_CRC_LO;
      end
      dcs_pkg::DCS_CRC_LO:
      begin
        push_valid = 1'b1;
        push_data  = crc_final[7:0];
        if (fifo_ready)
          state_next = dcs_pkg::DCS_IDLE;
      end
      dcs_pkg::DCS_OPCODE:
      begin
        if (rx)
        begin
          opcode_next = cmd_byte_in;
          if (cmd_reg == `DCS_CMD_STUFF)
          begin
            stuff_next = cpu_ok;
            state_next = dcs_pkg::DCS_IDLE;
          end
          else
            state_next = dcs_pkg::DCS_EXEC_LEN;
        end
      end
      dcs_pkg::DCS_EXEC_LEN:
      begin
        // Decoder outside sees the registered opcode and answers with the length
        instr_next.len   = len_eff;
        instr_next.bytes = {opcode_out, 32'h0000_0000};
        icnt_next        = 3'h1;
        if (len_eff == 3'h1)
        begin
          exec_next  = debug_mode_in;
          state_next = dcs_pkg::DCS_IDLE;
        end
        else
          state_next = dcs_pkg::DCS_EXEC_BYT;
      end
      dcs_pkg::DCS_EXEC_BYT:
      begin
        if (rx)
        begin
          instr_next.bytes[6'(39 - 8 * icnt_reg) -: 8] = cmd_byte_in;
          icnt_next = icnt_reg + 3'h1;
          if (icnt_reg + 3'h1 == instr_out.len)
          begin
            exec_next  = debug_mode_in;
            state_next = dcs_pkg::DCS_IDLE;
          end
        end
      end
      default: state_next = dcs_pkg::DCS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg     <= dcs_pkg::DCS_IDLE;
      cmd_reg       <= 8'h00;
      addr_reg      <= 16'h0000;
      cnt_reg       <= 17'h00000;
      crc_reg       <= `DCS_CRC_INIT;
      pcnt_reg      <= 16'h0000;
      pend_reg      <= 1'b0;
      icnt_reg      <= 3'h0;
      cmd_ready_out <= 1'b0;
      dmem_rd_out   <= 1'b0;
      dmem_addr_out <= 16'h0000;
      pmem_rd_out   <= 1'b0;
      pmem_addr_out <= 16'h0000;
      opcode_out    <= 8'h00;
      step_out      <= 1'b0;
      stuff_out     <= 1'b0;
      exec_out      <= 1'b0;
      instr_out     <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      addr_reg      <= addr_next;
      cnt_reg       <= cnt_next;
      crc_reg       <= crc_next;
      pcnt_reg      <= pcnt_next;
      pend_reg      <= pmem_rd_out;
      icnt_reg      <= icnt_next;
      cmd_ready_out <= takes_byte(state_next);
      dmem_rd_out   <= dmem_rd_next;
      dmem_addr_out <= addr_reg;
      pmem_rd_out   <= pmem_rd_next;
      pmem_addr_out <= pcnt_reg;
      opcode_out    <= opcode_next;
      step_out      <= step_next;
      stuff_out     <= stuff_next;
      exec_out      <= exec_next;
      instr_out     <= instr_next;
    end
  end

  // ----------------------------------------------------------------
  // Response buffer
  // ----------------------------------------------------------------
  dcs_fifo #(
    .WIDTH (8),
    .DEPTH (`DCS_FIFO_DEPTH)
  ) u_resp_fifo (
    .mclk_in      (mclk_in),
    .nrst_in      (nrst_in),
    .wr_valid_in  (push_valid),
    .wr_data_in   (push_data),
    .wr_ready_out (fifo_ready),
    .rd_valid_out (resp_valid_out),
    .rd_data_out  (resp_byte_out),
    .rd_ready_in  (resp_ready_in)
  );

endmodule

// [src/dcs_params.svh]
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define DCS_CMD_RD_DATA   8'h0d
`define DCS_CMD_RD_CRC    8'h0e
`define DCS_CMD_STEP      8'h10
`define DCS_CMD_STUFF     8'h11
`define DCS_CMD_EXEC      8'h12

// ----------------------------------------------------------------
// Values and sizes
// ----------------------------------------------------------------
`define DCS_BLANK_BYTE    8'hff
`define DCS_BLANK_CRC     16'hffff
`define DCS_CRC_INIT      16'hffff
`define DCS_CRC_POLY      16'h1021
`define DCS_PMEM_BYTES    16'h1000
`define DCS_FIFO_DEPTH    8
`define DCS_MAX_INSTR     3'h5

`endif

// [src/dcs_pkg.sv]
package dcs_pkg;

  typedef enum logic [3:0] {
    DCS_IDLE     = 4'h0,
    DCS_ADDR_HI  = 4'h1,
    DCS_ADDR_LO  = 4'h3,
    DCS_SIZE_HI  = 4'h2,
    DCS_SIZE_LO  = 4'h6,
    DCS_RD_ISSUE = 4'h7,
    DCS_RD_PUSH  = 4'h5,
    DCS_CRC_RUN  = 4'h4,
    DCS_CRC_HI   = 4'hc,
    DCS_CRC_LO   = 4'hd,
    DCS_OPCODE   = 4'hf,
    DCS_EXEC_LEN = 4'he,
    DCS_EXEC_BYT = 4'ha
  } dcs_state_t;

  // Instruction handed to the CPU; byte 0 sits in bits [39:32]
  typedef struct packed {
    logic [2:0]  len;
    logic [39:0] bytes;
  } dcs_instr_t;

endpackage

// [src/dcs_fifo.sv]
`timescale 1ns/1ns
module dcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  output logic                  rd_valid_out,
  output logic [WIDTH-1:0]      rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      cnt_reg;

  // Output stage is a register of its own, so the head word leaves storage
  wire push = wr_valid_in && wr_ready_out;
  wire load = (cnt_reg != '0) && (!rd_valid_out || rd_ready_in);

  assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wptr_reg     <= '0;
      rptr_reg     <= '0;
      cnt_reg      <= '0;
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wptr_reg] <= wr_data_in;
        wptr_reg          <= wptr_reg + 1'b1;
      end
      if (load)
      begin
        rd_data_out <= mem_reg[rptr_reg];
        rptr_reg    <= rptr_reg + 1'b1;
      end
      if (load)
        rd_valid_out <= 1'b1;
      else if (rd_ready_in)
        rd_valid_out <= 1'b0;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule

// [sim/dcs_mem_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Memory and CPU side stand-in
// ----------------------------------------
module dcs_mem_model (
  input  wire logic       mclk_in,
  input  wire logic       dmem_rd_in,
  input  wire logic [15:0] dmem_addr_in,
  output logic [7:0]      dmem_data_out,
  input  wire logic       pmem_rd_in,
  input  wire logic [15:0] pmem_addr_in,
  output logic [7:0]      pmem_data_out,
  input  wire logic [7:0] opcode_in,
  output logic [2:0]      instr_len_out
);
  // Data is valid one cycle only; otherwise the bus flips so stale bytes never pass
  initial dmem_data_out = 8'h00;
  initial pmem_data_out = 8'h00;
  // Plain always: the initial blocks above also write these variables
  always @(posedge mclk_in)
  begin
    dmem_data_out <= dmem_rd_in ? (dmem_addr_in[15:8] ^ dmem_addr_in[7:0] ^ 8'h5a)
                                : ~dmem_data_out;
    pmem_data_out <= pmem_rd_in ? (pmem_addr_in[7:0] ^ pmem_addr_in[11:4]) : ~pmem_data_out;
  end
  assign instr_len_out = opcode_in[2:0];
endmodule

// [sim/dcs_chk_sva.sv]
`timescale 1ns/1ns
module dcs_chk (
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        cmd_ready_out,
  input wire logic [7:0]  resp_byte_out,
  input wire logic        resp_valid_out,
  input wire logic        resp_ready_in,
  input wire logic        debug_mode_in,
  input wire logic        read_protect_in,
  input wire logic        dmem_rd_out,
  input wire logic [15:0] dmem_addr_out,
  input wire logic        pmem_rd_out,
  input wire logic [15:0] pmem_addr_out,
  input wire logic        step_out,
  input wire logic        stuff_out,
  input wire logic        exec_out
);
  logic        seen_reg;
  logic [15:0] prev_reg;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      seen_reg <= 1'b0;
      prev_reg <= 16'h0000;
    end
    else if (dmem_rd_out)
    begin
      seen_reg <= 1'b1;
      prev_reg <= dmem_addr_out;
    end
    else if (cmd_ready_out)
      seen_reg <= 1'b0;
  end
  sequence s_stall;
    resp_valid_out && !resp_ready_in;
  endsequence
  sequence s_scan;
    pmem_rd_out && $past(pmem_rd_out);
  endsequence
  a_step_gated:
    assert property (step_out |-> $past(debug_mode_in && !read_protect_in)) else $error("step");
  a_stuff_gated:
    assert property (stuff_out |-> $past(debug_mode_in && !read_protect_in)) else $error("stuff");
  a_exec_gated:
    assert property (exec_out |-> $past(debug_mode_in)) else $error("exec");
  a_dmem_blank:
    assert property (dmem_rd_out |-> debug_mode_in) else $error("data read outside debug");
  a_pmem_blank:
    assert property (pmem_rd_out |-> debug_mode_in) else $error("crc read outside debug");
  a_crc_scan_order:
    assert property (s_scan |-> pmem_addr_out == $past(pmem_addr_out) + 16'h0001)
      else $error("crc scan skipped");
  a_rd_addr_wrap:
    assert property (dmem_rd_out && seen_reg |-> dmem_addr_out == prev_reg + 16'h0001)
      else $error("read address step");
  a_resp_hold:
    assert property (s_stall |=> resp_valid_out && $stable(resp_byte_out))
      else $error("response dropped");
endmodule
bind dcs_top dcs_chk chk_u (.mclk_in, .nrst_in, .cmd_ready_out, .resp_byte_out,
  .resp_valid_out, .resp_ready_in, .debug_mode_in, .read_protect_in, .dmem_rd_out,
  .dmem_addr_out, .pmem_rd_out, .pmem_addr_out, .step_out, .stuff_out, .exec_out);

// [sim/test_debug_command_subset.sv]
`timescale 1ns/1ns
`include "dcs_params.svh"
module test_debug_command_subset;
  logic mclk_in = 0, nrst_in = 0, cmd_valid_in = 0, resp_ready_in = 0, hold = 0;
  logic debug_mode_in = 0, read_protect_in = 0, dmem_rd_out, pmem_rd_out, cmd_ready_out;
  logic step_out, stuff_out, exec_out, resp_valid_out;
  logic [7:0] cmd_byte_in = 8'h00, resp_byte_out, dmem_data_in, pmem_data_in, opcode_out;
  logic [15:0] dmem_addr_out, pmem_addr_out;
  logic [2:0] instr_len_in;
  dcs_pkg::dcs_instr_t instr_out, ins;
  logic [7:0] rq[$];
  int fails = 0, samples_checked = 0, cyc = 0, n_step, n_stuff, n_exec, n_rd, t0;
  dcs_top dut_u (.mclk_in, .nrst_in, .cmd_byte_in, .cmd_valid_in, .cmd_ready_out,
    .resp_byte_out, .resp_valid_out, .resp_ready_in, .debug_mode_in, .read_protect_in,
    .dmem_rd_out, .dmem_addr_out, .dmem_data_in, .pmem_rd_out, .pmem_addr_out,
    .pmem_data_in, .opcode_out, .instr_len_in, .step_out, .stuff_out, .exec_out, .instr_out);
  dcs_mem_model mem_u (.mclk_in, .dmem_rd_in(dmem_rd_out), .dmem_addr_in(dmem_addr_out),
    .dmem_data_out(dmem_data_in), .pmem_rd_in(pmem_rd_out), .pmem_addr_in(pmem_addr_out),
    .pmem_data_out(pmem_data_in), .opcode_in(opcode_out), .instr_len_out(instr_len_in));
  initial forever #5 mclk_in = ~mclk_in;
  // Consumer stalls one cycle in four so the response path sees back-pressure
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    resp_ready_in <= !hold && cyc[1:0] != 2'h0;
    if (cyc >= 40000)
    begin
      fails++;
      end_sim();
    end
  end
  // Registered outputs are settled mid-cycle, so sample there to avoid edge races
  always @(negedge mclk_in)
  begin
    if (resp_valid_out === 1'b1 && resp_ready_in === 1'b1) rq.push_back(resp_byte_out);
    n_step += int'(step_out === 1'b1);
    n_stuff += int'(stuff_out === 1'b1);
    n_exec += int'(exec_out === 1'b1);
    n_rd += int'(dmem_rd_out === 1'b1);
    if (exec_out === 1'b1) ins = instr_out;
  end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset();
    nrst_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    rq.delete();
  endtask
  task automatic send(input logic [7:0] b);
    cmd_byte_in <= b;
    cmd_valid_in <= 1'b1;
    do @(negedge mclk_in); while (cmd_ready_out !== 1'b1);
    @(posedge mclk_in);
  endtask
  task automatic idle(input logic dbg, input logic prot);
    cmd_valid_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    debug_mode_in <= dbg;
    read_protect_in <= prot;
    @(posedge mclk_in);
  endtask
  // Counters are cleared only here, after the idle, so pulses seen during this idle are dropped
  task automatic fresh(input logic dbg, input logic prot);
    idle(dbg, prot);
    n_step = 0;
    n_stuff = 0;
    n_exec = 0;
    n_rd = 0;
    rq.delete();
  endtask
  task automatic getn(input int n);
    repeat (6000) if (rq.size() < n) @(posedge mclk_in);
    chk("response count", 24'(n), 24'(rq.size()));
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] n);
    send(`DCS_CMD_RD_DATA);
    send(a[15:8]);
    send(a[7:0]);
    send(n[15:8]);
    send(n[7:0]);
    cmd_valid_in <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_read();
    logic [15:0] a;
    fresh(1'b1, 1'b0);
    hold <= 1'b1;
    rd(16'hfffa, 16'h000c);
    repeat (80) @(posedge mclk_in);
    chk("reads while full", 24'h1, 24'(n_rd <= 10 && n_rd >= 8));
    hold <= 1'b0;
    getn(12);
    for (int i = 0; i < 12; i++)
    begin
      a = 16'hfffa + 16'(i);
      chk("read byte", 24'(a[15:8] ^ a[7:0] ^ 8'h5a), 24'(rq[i]));
    end
    $display("read done");
  endtask
  task automatic t_blank_zero();
    fresh(1'b0, 1'b0);
    rd(16'h0040, 16'h0000);
    getn(20);
    foreach (rq[i]) chk("blank byte", 24'(`DCS_BLANK_BYTE), 24'(rq[i]));
    chk("dmem reads", 24'h0, 24'(n_rd));
    do_reset();
    $display("zero size done");
  endtask
  task automatic t_crc(input logic dbg);
    logic [15:0] c;
    c = `DCS_CRC_INIT;
    for (int a = 0; a < `DCS_PMEM_BYTES; a++)
    begin
      c ^= {(8'(a) ^ 8'(a >> 4)), 8'h00};
      repeat (8) c = c[15] ? ((c << 1) ^ `DCS_CRC_POLY) : (c << 1);
    end
    if (!dbg) c = `DCS_BLANK_CRC;
    fresh(dbg, 1'b0);
    t0 = cyc;
    send(`DCS_CMD_RD_CRC);
    cmd_valid_in <= 1'b0;
    getn(2);
    chk("crc", 24'(c), 24'({rq[0], rq[1]}));
    if (dbg) chk("crc delay", 24'h1, 24'(cyc - t0 >= `DCS_PMEM_BYTES));
    $display("crc done");
  endtask
  task automatic t_gate();
    for (int m = 0; m < 4; m++)
    begin
      fresh(m[0], m[1]);
      send(`DCS_CMD_STEP);
      send(`DCS_CMD_STUFF);
      send(8'h02);
      idle(m[0], m[1]);
      chk("step count", 24'(m == 1), 24'(n_step));
      chk("opcode", 24'h02, 24'(opcode_out));
      fresh(m[0], m[1]);
      send(`DCS_CMD_STUFF);
      send(8'h34);
      idle(m[0], m[1]);
      chk("stuff count", 24'(m == 1), 24'(n_stuff));
      chk("opcode", 24'h34, 24'(opcode_out));
    end
    $display("gate done");
  endtask
  task automatic t_exec();
    for (int d = 1; d >= 0; d--)
    begin
      fresh(d[0], 1'b1);
      send(`DCS_CMD_EXEC);
      send(8'h03);
      send(8'ha1);
      send(8'hb2);
      idle(d[0], 1'b1);
      chk("exec count", 24'(d), 24'(n_exec));
    end
    chk("instr bytes", 24'h03a1b2, ins.bytes[39:16]);
    chk("instr len", 24'h3, 24'(ins.len));
    // Opcode whose decoded length is zero runs as a one-byte instruction
    fresh(1'b1, 1'b0);
    send(`DCS_CMD_EXEC);
    send(8'h08);
    idle(1'b1, 1'b0);
    chk("short exec count", 24'h1, 24'(n_exec));
    chk("short len", 24'h1, 24'(ins.len));
    chk("short opcode", 24'h08, 24'(ins.bytes[39:32]));
    $display("exec done");
  endtask
  task automatic t_unknown();
    fresh(1'b1, 1'b0);
    send(8'h55);
    send(`DCS_CMD_STEP);
    idle(1'b1, 1'b0);
    chk("step after unknown", 24'h1, 24'(n_step));
    chk("stray responses", 24'h0, 24'(rq.size()));
    $display("unknown done");
  endtask
  initial
  begin
    do_reset();
    t_read();
    t_blank_zero();
    t_crc(1'b1);
    t_crc(1'b0);
    t_gate();
    t_exec();
    t_unknown();
    end_sim();
  end
endmodule
